// file: design/osc_clock_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - enable code 00 off, 11 runs unless suspended
// - writing suspend bit halts oscillator until wake
// - frequency-ready reads one only at programmed frequency
// - reserved control bit 3 reads zero
// - divider code 000 divides 128, 111 by 1
// - reset selects oscillator, divider at 128
// - seven-bit coarse trim, top bit reads zero
// - coarse trim loads factory value at reset
// - six-bit fine trim, factory value, top zeros
// - multiplier output four times input, then scaled
// - multiplier input from three oscillator sources
// - slow input gives four pulses per period
// - multiplier ready zero until locked; init reads zero while enabled
// - scale codes 0-2 map to 1, codes 3-7 to 2/3,1/2,2/5,1/3,2/7
module osc_clock_ctrl (
  input  wire logic                   clock,
  input  wire logic                   rst,
  // classic wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [9:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // oscillator analog side
  input  wire logic [6:0]             factoryCoarse,
  input  wire logic [5:0]             factoryFine,
  input  wire logic                   oscReadyRaw,
  input  wire logic                   wakeEvent,
  input  wire logic                   extOscIn,
  input  wire logic                   mulLockRaw,
  output logic                        oscRun,
  output logic      [6:0]             coarseTrim,
  output logic      [5:0]             fineTrim,
  output logic                        systemClockEn,
  output osc_clock_pkg::mul_pins_t    mulPins,
  output logic                        mulClockEn
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [1:0] rdySync_q;
  logic [1:0] lockSync_q;
  logic [1:0] wakeSync_q;
  logic [1:0] extSync_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      rdySync_q  <= 2'h0;
      lockSync_q <= 2'h0;
      wakeSync_q <= 2'h0;
      extSync_q  <= 2'h0;
    end else begin
      rdySync_q  <= {rdySync_q[0], oscReadyRaw};
      lockSync_q <= {lockSync_q[0], mulLockRaw};
      wakeSync_q <= {wakeSync_q[0], wakeEvent};
      extSync_q  <= {extSync_q[0], extOscIn};
    end
  end

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic       busReq;
  logic       wrLow;
  logic [7:0] regIdx;
  logic       hitCtl;
  logic       hitCoarse;
  logic       hitFine;
  logic       hitMul;
  logic       ack_q;

  assign busReq    = wb_cyc_i && wb_stb_i && !ack_q;
  assign wrLow     = busReq && wb_we_i && wb_sel_i[0];
  assign regIdx    = wb_adr_i[9:2];
  assign hitCtl    = regIdx == osc_clock_pkg::IDX_OSC_CONTROL;
  assign hitCoarse = regIdx == osc_clock_pkg::IDX_COARSE_TRIM;
  assign hitFine   = regIdx == osc_clock_pkg::IDX_FINE_TRIM;
  assign hitMul    = regIdx == osc_clock_pkg::IDX_MUL_CONTROL;

  // ------------------------------------------------------------
  // oscillator control
  // ------------------------------------------------------------
  logic [1:0] oscEn_q;
  logic       suspend_q;
  logic [2:0] divSel_q;
  logic       running;
  logic       freqReady;

  always_ff @(posedge clock) begin
    if (rst) begin
      oscEn_q  <= osc_clock_pkg::OSC_EN_RST;
      divSel_q <= osc_clock_pkg::DIV_RST;
    end else if (wrLow && hitCtl) begin
      oscEn_q  <= wb_dat_i[osc_clock_pkg::OSC_EN_HI:osc_clock_pkg::OSC_EN_LO];
      divSel_q <= wb_dat_i[osc_clock_pkg::OSC_DIV_HI:0];
    end
  end

  // a suspend write in the same cycle as a wake still suspends
  always_ff @(posedge clock) begin
    if (rst) begin
      suspend_q <= 1'b0;
    end else if (wrLow && hitCtl && wb_dat_i[osc_clock_pkg::OSC_SUSPEND]) begin
      suspend_q <= 1'b1;
    end else if (wakeSync_q[1]) begin
      suspend_q <= 1'b0;
    end
  end

  // reserved codes 01 and 10 are treated as off
  assign running   = (oscEn_q == osc_clock_pkg::OSC_EN_ON) && !suspend_q;
  assign freqReady = running && rdySync_q[1];

  always_ff @(posedge clock) begin
    if (rst) begin
      oscRun <= 1'b0;
    end else begin
      oscRun <= running;
    end
  end

  // ------------------------------------------------------------
  // system clock divider
  // ------------------------------------------------------------
  logic [6:0] divCnt_q;
  logic [6:0] divMask;

  assign divMask = osc_clock_pkg::DIV_MASK_MAX >> divSel_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      divCnt_q <= 7'h0;
    end else if (running) begin
      divCnt_q <= divCnt_q + 7'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      systemClockEn <= 1'b0;
    end else begin
      systemClockEn <= running && ((divCnt_q & divMask) == divMask);
    end
  end

  // ------------------------------------------------------------
  // trim registers
  // ------------------------------------------------------------
  // factory value is taken at the synchronous reset edge
  always_ff @(posedge clock) begin
    if (rst) begin
      coarseTrim <= factoryCoarse;
    end else if (wrLow && hitCoarse) begin
      coarseTrim <= wb_dat_i[osc_clock_pkg::COARSE_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fineTrim <= factoryFine;
    end else if (wrLow && hitFine) begin
      fineTrim <= wb_dat_i[osc_clock_pkg::FINE_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // multiplier control register
  // ------------------------------------------------------------
  logic       multiplier_enable_q;
  logic       multiplier_initialise_q;
  logic [1:0] multiplier_input_select_q;
  logic [2:0] multiplier_scale_select_q;
  logic       mulReady;
  logic       initWrite;

  // init only acts once the multiplier is already enabled
  assign initWrite = wrLow && hitMul && multiplier_enable_q && wb_dat_i[osc_clock_pkg::MUL_INIT];
  assign mulReady  = multiplier_enable_q && lockSync_q[1];

  always_ff @(posedge clock) begin
    if (rst) begin
      multiplier_enable_q  <= 1'b0;
      multiplier_input_select_q <= 2'h0;
      multiplier_scale_select_q <= 3'h0;
    end else if (wrLow && hitMul) begin
      multiplier_enable_q  <= wb_dat_i[osc_clock_pkg::MUL_EN];
      multiplier_input_select_q <= wb_dat_i[osc_clock_pkg::MUL_SEL_HI:0];
      multiplier_scale_select_q <= wb_dat_i[osc_clock_pkg::MUL_DIV_HI:osc_clock_pkg::MUL_DIV_LO];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      multiplier_initialise_q <= 1'b0;
    end else if (wrLow && hitMul) begin
      multiplier_initialise_q <= !multiplier_enable_q && wb_dat_i[osc_clock_pkg::MUL_INIT];
    end else if (multiplier_enable_q) begin
      multiplier_initialise_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mulPins <= '0;
    end else begin
      mulPins <= '{multiplier_enable_q, initWrite, multiplier_input_select_q, multiplier_scale_select_q};
    end
  end

  // ------------------------------------------------------------
  // multiplier input and burst pulse model
  // ------------------------------------------------------------
  logic       intHalf_q;
  logic       extHalf_q;
  logic       extPrev_q;
  logic       mulIn;
  logic       mulInPrev_q;
  logic [2:0] burst_q;
  logic       baseTick;
  logic       burstStart;

  always_ff @(posedge clock) begin
    if (rst) begin
      intHalf_q <= 1'b0;
      extHalf_q <= 1'b0;
      extPrev_q <= 1'b0;
    end else begin
      intHalf_q <= running ? !intHalf_q : intHalf_q;
      extPrev_q <= extSync_q[1];
      if (extSync_q[1] && !extPrev_q) begin
        extHalf_q <= !extHalf_q;
      end
    end
  end

  // codes 1x both take the undivided external source
  always_comb begin
    unique case (multiplier_input_select_q)
      osc_clock_pkg::SEL_INT_HALF: mulIn = intHalf_q;
      osc_clock_pkg::SEL_EXT_HALF: mulIn = extHalf_q;
      default:                     mulIn = extSync_q[1];
    endcase
  end

  // four fast pulses per rising input edge, idle until the next rising edge
  always_ff @(posedge clock) begin
    if (rst) begin
      mulInPrev_q <= 1'b0;
      burst_q     <= 3'h0;
    end else begin
      mulInPrev_q <= mulIn;
      if (burstStart) begin
        burst_q <= osc_clock_pkg::BURST_LEN;
      end else if (burst_q != 3'h0) begin
        burst_q <= burst_q - 3'h1;
      end
    end
  end

  assign burstStart = multiplier_enable_q && mulIn && !mulInPrev_q;
  assign baseTick = burst_q != 3'h0;

  // ------------------------------------------------------------
  // output scaling: keep two of every n base ticks
  // ------------------------------------------------------------
  logic [2:0] scaleCnt_q;
  logic       scaleOne;
  logic       keepTick;

  assign scaleOne = multiplier_scale_select_q < osc_clock_pkg::SCALE_2_3;
  assign keepTick = scaleOne || (scaleCnt_q < osc_clock_pkg::SCALE_KEEP);

  // uneven keep pattern is why odd factors are not 50 percent duty
  always_ff @(posedge clock) begin
    if (rst) begin
      scaleCnt_q <= 3'h0;
    end else if (baseTick) begin
      scaleCnt_q <= (scaleOne || scaleCnt_q == multiplier_scale_select_q - 3'h1) ? 3'h0
                                                                : scaleCnt_q + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mulClockEn <= 1'b0;
    end else begin
      mulClockEn <= baseTick && keepTick;
    end
  end

  // ------------------------------------------------------------
  // read path and acknowledge
  // ------------------------------------------------------------
  logic [7:0] rdByte;

  always_comb begin
    rdByte = 8'h0;
    if (hitCtl) begin
      rdByte = {oscEn_q, suspend_q, freqReady, 1'b0, divSel_q};
    end else if (hitCoarse) begin
      rdByte = {1'b0, coarseTrim};
    end else if (hitFine) begin
      rdByte = {2'h0, fineTrim};
    end else if (hitMul) begin
      rdByte = {multiplier_enable_q, multiplier_initialise_q && !multiplier_enable_q, mulReady, multiplier_scale_select_q, multiplier_input_select_q};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_q    <= busReq;
      wb_dat_o <= busReq ? {24'h0, rdByte} : 32'h0;
    end
  end

  assign wb_ack_o = ack_q;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  osc_off_a: assert property ((oscEn_q == osc_clock_pkg::OSC_EN_OFF) |=> !oscRun)
    else $error("oscillator runs while enable field is off");
  suspend_halts_a: assert property (
    (wrLow && hitCtl && wb_dat_i[osc_clock_pkg::OSC_SUSPEND]) |=> ##1 !oscRun)
    else $error("suspend write did not halt oscillator");
  freq_ready_a: assert property (
    (wb_ack_o && $past(hitCtl) && wb_dat_o[osc_clock_pkg::OSC_FREQ_RDY]) |-> $past(running))
    else $error("frequency ready read while oscillator stopped");
  reserved_zero_a: assert property (wb_ack_o && $past(hitCtl) |-> wb_dat_o[3] == 1'b0)
    else $error("reserved control bit read nonzero");
  div_one_a: assert property (
    (running && divSel_q == osc_clock_pkg::DIV_BY_ONE) |=> systemClockEn)
    else $error("divide by one missed a cycle");
  reset_div_a: assert property (
    $fell(rst) |-> divSel_q == osc_clock_pkg::DIV_RST && oscEn_q == osc_clock_pkg::OSC_EN_RST)
    else $error("reset did not select divide by 128");
  coarse_top_a: assert property (wb_ack_o && $past(hitCoarse) |-> wb_dat_o[7] == 1'b0)
    else $error("coarse trim top bit read nonzero");
  factory_load_a: assert property (
    $fell(rst) |-> coarseTrim == $past(factoryCoarse) && fineTrim == $past(factoryFine))
    else $error("trim not loaded with factory value");
  burst_four_a: assert property (burstStart |=> baseTick [*4])
    else $error("slow input burst shorter than four pulses");
  burst_end_a: assert property (burstStart ##1 (!burstStart) [*4] |=> !baseTick)
    else $error("slow input burst longer than four pulses");
  scale_one_a: assert property ((baseTick && scaleOne) |=> mulClockEn)
    else $error("unit scale dropped a base pulse");
  mul_ready_a: assert property (
    !lockSync_q[1] |=> !(wb_ack_o && $past(hitMul) && wb_dat_o[osc_clock_pkg::MUL_RDY]))
    else $error("multiplier ready read before lock");
  sync_path_a: assert property ($rose(rdySync_q[1]) |-> $past(rdySync_q[0]))
    else $error("ready bypassed the synchroniser");
endmodule

// file: design/osc_clock_pkg.sv
package osc_clock_pkg;

  // ------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_FINE_TRIM    = 8'h9e;
  localparam logic [7:0] IDX_OSC_CONTROL  = 8'ha1;
  localparam logic [7:0] IDX_COARSE_TRIM  = 8'ha2;
  localparam logic [7:0] IDX_MUL_CONTROL  = 8'h97;

  // ------------------------------------------------------------
  // internal_osc_control fields
  // ------------------------------------------------------------
  localparam int OSC_EN_HI      = 7;
  localparam int OSC_EN_LO      = 6;
  localparam int OSC_SUSPEND    = 5;
  localparam int OSC_FREQ_RDY   = 4;
  localparam int OSC_DIV_HI     = 2;
  localparam logic [1:0] OSC_EN_OFF = 2'h0;
  localparam logic [1:0] OSC_EN_ON  = 2'h3;
  localparam logic [1:0] OSC_EN_RST = 2'h3;
  localparam logic [2:0] DIV_RST    = 3'h0;
  localparam logic [2:0] DIV_BY_ONE = 3'h7;
  localparam logic [6:0] DIV_MASK_MAX = 7'h7f;

  // ------------------------------------------------------------
  // trim fields
  // ------------------------------------------------------------
  localparam int COARSE_W = 7;
  localparam int FINE_W   = 6;

  // ------------------------------------------------------------
  // multiplier_control fields
  // ------------------------------------------------------------
  localparam int MUL_EN      = 7;
  localparam int MUL_INIT    = 6;
  localparam int MUL_RDY     = 5;
  localparam int MUL_DIV_HI  = 4;
  localparam int MUL_DIV_LO  = 2;
  localparam int MUL_SEL_HI  = 1;
  localparam logic [1:0] SEL_INT_HALF = 2'h0;
  localparam logic [1:0] SEL_EXT_HALF = 2'h1;
  localparam logic [2:0] SCALE_2_3 = 3'h3;
  localparam logic [2:0] SCALE_2_7 = 3'h7;
  localparam logic [2:0] SCALE_KEEP = 3'h2;
  localparam logic [2:0] BURST_LEN  = 3'h4;

  typedef struct packed {
    logic       enable;
    logic       initPulse;
    logic [1:0] inputSel;
    logic [2:0] scale;
  } mul_pins_t;

endpackage

// file: dv/tb_osc_clock_ctrl.sv
`timescale 1ns/1ps
module tb_osc_clock_ctrl;
  logic                      clock;
  logic                      rst;
  logic                      wbCyc;
  logic                      wbStb;
  logic                      wbWe;
  logic [9:0]                wbAdr;
  logic [3:0]                wbSel;
  logic [31:0]               wbDatIn;
  logic [31:0]               wbDatOut;
  logic                      wbAck;
  logic [6:0]                factoryCoarse;
  logic [5:0]                factoryFine;
  logic                      oscReadyRaw;
  logic                      wakeEvent;
  logic                      extOscIn;
  logic                      mulLockRaw;
  logic                      oscRun;
  logic [6:0]                coarseTrim;
  logic [5:0]                fineTrim;
  logic                      systemClockEn;
  osc_clock_pkg::mul_pins_t  mulPins;
  logic                      mulClockEn;
  logic [31:0]               rd;
  logic                      initSeen;
  int                        errCount;
  int                        checksDone;
  int                        p;
  int                        n;

  osc_clock_ctrl i_osc_clock_ctrl (
    .clock(clock), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatIn), .wb_dat_o(wbDatOut),
    .wb_ack_o(wbAck), .factoryCoarse(factoryCoarse), .factoryFine(factoryFine),
    .oscReadyRaw(oscReadyRaw), .wakeEvent(wakeEvent), .extOscIn(extOscIn),
    .mulLockRaw(mulLockRaw), .oscRun(oscRun), .coarseTrim(coarseTrim), .fineTrim(fineTrim),
    .systemClockEn(systemClockEn), .mulPins(mulPins), .mulClockEn(mulClockEn)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    checksDone++;
    if (act !== exp) begin
      errCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic summarize;
    $display("errors=%0d checks=%0d", errCount, checksDone);
    if (errCount == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // a wait that ran out counts as a mismatch and ends the run
  task automatic limitHit(input logic ok);
    if (!ok) begin
      errCount++;
      summarize();
    end
  endtask

  // request held until ack is sampled, then released
  task automatic busCycle(input logic w, input logic [7:0] idx, input logic [7:0] d,
                          output logic [31:0] q);
    int k;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbSel <= 4'hf;
    wbAdr <= {idx, 2'b00};
    wbDatIn <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wbAck !== 1'b1 && k < 20);
    if (wbAck !== 1'b1) begin
      errCount++;
      summarize();
    end
    q = wbDatOut;
    initSeen = mulPins.initPulse;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    busCycle(1'b1, idx, d, q);
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    busCycle(1'b0, idx, 8'h00, rd);
    check(rd, {24'h0, exp});
  endtask

  task automatic period(output int c);
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (systemClockEn !== 1'b1 && k < 300);
    limitHit(systemClockEn === 1'b1);
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (systemClockEn !== 1'b1 && c < 300);
    limitHit(systemClockEn === 1'b1);
  endtask

  function automatic int kept(input int s);
    case (s)
      3: kept = 280;
      4: kept = 210;
      5: kept = 168;
      6: kept = 140;
      7: kept = 120;
      default: kept = 420;
    endcase
  endfunction

  // slow input: 20-cycle period, counts every kept output pulse
  task automatic pulses(input logic [7:0] cfg, input int edges, input int exp);
    int cnt;
    cnt = 0;
    wr(osc_clock_pkg::IDX_MUL_CONTROL, cfg);
    repeat (20) @(posedge clock);
    check(32'(mulPins), {25'h0, 2'b10, cfg[1:0], cfg[4:2]});
    for (int e = 0; e <= edges; e++) begin
      for (int c = 0; c < 20; c++) begin
        @(posedge clock);
        extOscIn <= (c < 10) && (e < edges);
        if (mulClockEn === 1'b1) cnt++;
      end
    end
    check(32'(cnt), 32'(exp));
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 10'h000;
    wbSel = 4'hf;
    wbDatIn = 32'h0;
    factoryCoarse = 7'h55;
    factoryFine = 6'h2a;
    oscReadyRaw = 1'b1;
    wakeEvent = 1'b0;
    extOscIn = 1'b0;
    mulLockRaw = 1'b0;
    errCount = 0;
    checksDone = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    // ready flag needs two edges through its synchroniser
    repeat (2) @(posedge clock);
    rdChk(osc_clock_pkg::IDX_OSC_CONTROL, 8'hd0);
    rdChk(osc_clock_pkg::IDX_COARSE_TRIM, 8'h55);
    rdChk(osc_clock_pkg::IDX_FINE_TRIM, 8'h2a);
    rdChk(osc_clock_pkg::IDX_MUL_CONTROL, 8'h00);
    check(32'(fineTrim), 32'h2a);
    wr(osc_clock_pkg::IDX_COARSE_TRIM, 8'hff);
    rdChk(osc_clock_pkg::IDX_COARSE_TRIM, 8'h7f);
    check(32'(coarseTrim), 32'h7f);
    wr(osc_clock_pkg::IDX_FINE_TRIM, 8'hff);
    rdChk(osc_clock_pkg::IDX_FINE_TRIM, 8'h3f);
    wr(8'h10, 8'hff);
    rdChk(8'h10, 8'h00);
    wr(osc_clock_pkg::IDX_OSC_CONTROL, 8'hc0);
    rdChk(osc_clock_pkg::IDX_OSC_CONTROL, 8'hd0);
    for (int code = 0; code < 8; code++) begin
      wr(osc_clock_pkg::IDX_OSC_CONTROL, 8'(8'hc0 | code));
      period(p);
      period(p);
      check(32'(p), 32'(128 >> code));
    end
    for (int i = 0; i < 4; i++) begin
      wr(osc_clock_pkg::IDX_OSC_CONTROL, {i[1:0], 6'h07});
      repeat (4) @(posedge clock);
      check(32'(oscRun), 32'(i == 3));
    end
    rdChk(osc_clock_pkg::IDX_OSC_CONTROL, 8'hd7);
    oscReadyRaw <= 1'b0;
    repeat (5) @(posedge clock);
    rdChk(osc_clock_pkg::IDX_OSC_CONTROL, 8'hc7);
    oscReadyRaw <= 1'b1;
    wr(osc_clock_pkg::IDX_OSC_CONTROL, 8'he7);
    repeat (4) @(posedge clock);
    check(32'(oscRun), 32'h0);
    rdChk(osc_clock_pkg::IDX_OSC_CONTROL, 8'he7);
    wakeEvent <= 1'b1;
    repeat (4) @(posedge clock);
    wakeEvent <= 1'b0;
    repeat (4) @(posedge clock);
    check(32'(oscRun), 32'h1);
    rdChk(osc_clock_pkg::IDX_OSC_CONTROL, 8'hd7);
    // clear, configure, enable, wait over 5 us, initialise, poll
    wr(osc_clock_pkg::IDX_MUL_CONTROL, 8'h00);
    wr(osc_clock_pkg::IDX_MUL_CONTROL, 8'h02);
    wr(osc_clock_pkg::IDX_MUL_CONTROL, 8'h82);
    repeat (260) @(posedge clock);
    wr(osc_clock_pkg::IDX_MUL_CONTROL, 8'hc2);
    check(32'(initSeen), 32'h1);
    rdChk(osc_clock_pkg::IDX_MUL_CONTROL, 8'h82);
    mulLockRaw <= 1'b1;
    n = 0;
    do begin
      busCycle(1'b0, osc_clock_pkg::IDX_MUL_CONTROL, 8'h00, rd);
      n++;
    end while (rd[5] !== 1'b1 && n < 10);
    limitHit(rd[5] === 1'b1);
    check(rd, 32'ha2);
    for (int s = 0; s < 8; s++) begin
      pulses(8'(8'h82 | (s << 2)), 105, kept(s));
    end
    pulses(8'h81, 106, 212);
    pulses(8'h83, 105, 420);
    // internal source halved outruns the bench clock: an output every cycle
    pulses(8'h80, 0, 20);
    wr(osc_clock_pkg::IDX_COARSE_TRIM, 8'h11);
    rst <= 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    rdChk(osc_clock_pkg::IDX_COARSE_TRIM, 8'h55);
    rdChk(osc_clock_pkg::IDX_OSC_CONTROL, 8'hd0);
    summarize();
  end
endmodule
